// ### capture_edge.sv
// Edge detector for the capture trigger input
`timescale 1ns/1ns
`default_nettype none
module capture_edge (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       pin,
    input  wire logic [1:0] edge_cfg,
    output logic            hit
);
    logic prev;
    logic next_prev;

    always_comb begin
        next_prev = pin;
        hit = (edge_cfg[timer0_pkg::RISE_BIT] & pin & ~prev)
            | (edge_cfg[timer0_pkg::FALL_BIT] & ~pin & prev);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
        end else if (ce) begin
            prev <= next_prev;
        end
    end
endmodule
`default_nettype wire

// ### pin_model.sv
// Far-side model of the count pin and the capture trigger pin
`timescale 1ns/1ns
`default_nettype none
module pin_model (
    input  wire logic core_clk,
    output logic      ext_pin,
    output logic      trig_pin
);
    // ==========================================
    // Pin drivers
    // Both pins are plain inputs on the device side, so they idle low
    initial begin
        ext_pin  = 1'b0;
        trig_pin = 1'b0;
    end

    // Slow pulses, three cycles high and four low between pulses, so every edge is seen
    task automatic pulse_ext(input int n);
        repeat (n) begin
            @(posedge core_clk) ext_pin <= 1'b1;
            repeat (3) @(posedge core_clk);
            ext_pin <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask

    task automatic pulse_trig;
        @(posedge core_clk) trig_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        trig_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ### test_eight_bit_timer_pwm_capture.sv
// Self-checking bench for the 8-bit timer with PWM and capture
`timescale 1ns/1ns
`default_nettype none
module test_eight_bit_timer_pwm_capture;
    logic        core_clk;
    logic        rst_b;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_pin;
    logic        trig_pin;
    logic        tog;
    logic        pwm;
    logic        mflag;
    logic        oflag;
    logic        last_err;
    logic [31:0] rd;
    int          error_cnt;
    int          samples_checked;
    int          div_tab [7] = '{2, 4, 8, 32, 128, 512, 2048};

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    timer0_core uut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(ext_pin), .capture_trigger_input(trig_pin),
        .match_toggle_output(tog), .pulse_width_output(pwm),
        .match_flag(mflag), .overflow_flag(oflag));

    pin_model pins (.core_clk(core_clk), .ext_pin(ext_pin), .trig_pin(trig_pin));

    // ==========================================
    // Shared tasks
    task automatic close_out;
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic timeout;
        $display("[ERR] t=%0t timeout got=%h exp=%h", $time, 32'h0, 32'h1);
        error_cnt++;
        close_out;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask

    // Holds the request until pready is sampled high, then releases
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd       = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            timeout;
    endtask

    function automatic logic pick(input int w);
        return w ? pwm : tog;
    endfunction

    // Counts the cycles left at the present level
    task automatic len_at(input int w, output logic lvl, output int n);
        lvl = pick(w);
        n = 0;
        while (pick(w) === lvl && n < 6000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 6000)
            timeout;
    endtask

    // Waits for a level change, then counts cycles at the new level
    task automatic run_len(input int w, output logic lvl, output int n);
        int   k;
        logic p;
        p = pick(w);
        k = 0;
        while (pick(w) === p && k < 6000) begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 6000)
            timeout;
        len_at(w, lvl, n);
    endtask

    // ==========================================
    // Scenarios
    task automatic reset_values;
        apb(1'b0, timer0_pkg::ADDR_CTRL, 8'h00);
        chk(rd, 32'h00);
        apb(1'b0, timer0_pkg::ADDR_COUNT, 8'h00);
        chk(rd, 32'h00);
        apb(1'b0, timer0_pkg::ADDR_DATA, 8'h00);
        chk(rd, 32'hFF);
        apb(1'b0, timer0_pkg::ADDR_FLAGS, 8'h00);
        chk(rd, 32'h00);
        apb(1'b0, timer0_pkg::ADDR_EDGE, 8'h00);
        chk(rd, 32'h01);
        apb(1'b0, 12'h000, 8'h00);
        chk({31'h0, last_err}, 32'h1);
    endtask

    // Compare of zero matches on every tick, so the toggle spacing is the tap
    task automatic clock_taps;
        logic lvl;
        int   n;
        apb(1'b1, timer0_pkg::ADDR_DATA, 8'h00);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h80 | (8'(i) << 1));
            run_len(0, lvl, n);
            run_len(0, lvl, n);
            chk(32'(n), 32'(div_tab[i]));
            if (i == 0) begin
                // Clock enable low must freeze the fast toggling output
                @(posedge core_clk) ce <= 1'b0;
                @(posedge core_clk);
                lvl = tog;
                repeat (9) @(posedge core_clk);
                chk({31'h0, tog}, {31'h0, lvl});
                ce <= 1'b1;
            end
        end
        chk({31'h0, mflag}, 32'h1);
        // Stop matching first, so no new set hides the clear
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h00);
        apb(1'b0, timer0_pkg::ADDR_FLAGS, 8'h00);
        chk(rd, 32'h01);
        apb(1'b1, timer0_pkg::ADDR_FLAGS, 8'h00);
        @(posedge core_clk);
        chk({31'h0, mflag}, 32'h0);
    endtask

    task automatic sw_clear;
        logic [31:0] a;
        apb(1'b1, timer0_pkg::ADDR_DATA, 8'hFF);
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h80);
        repeat (40) @(posedge core_clk);
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h00);
        apb(1'b0, timer0_pkg::ADDR_COUNT, 8'h00);
        a = rd;
        chk({31'h0, (a != 32'h0)}, 32'h1);
        repeat (20) @(posedge core_clk);
        apb(1'b0, timer0_pkg::ADDR_COUNT, 8'h00);
        chk(rd, a);
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h01);
        apb(1'b0, timer0_pkg::ADDR_COUNT, 8'h00);
        chk(rd, 32'h00);
        apb(1'b0, timer0_pkg::ADDR_CTRL, 8'h00);
        chk(rd, 32'h00);
    endtask

    task automatic ext_count;
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h8E);
        pins.pulse_ext(5);
        apb(1'b0, timer0_pkg::ADDR_COUNT, 8'h00);
        chk(rd, 32'h05);
    endtask

    // High from wrap to match, low from match to wrap; no clear on match
    task automatic pwm_mode;
        logic lvl;
        int   n;
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h01);
        apb(1'b1, timer0_pkg::ADDR_FLAGS, 8'h00);
        apb(1'b1, timer0_pkg::ADDR_DATA, 8'h40);
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h90);
        run_len(1, lvl, n);
        chk(32'(n), 32'd128);
        len_at(1, lvl, n);
        chk(32'(n), 32'd384);
        chk({31'h0, oflag}, 32'h1);
    endtask

    task automatic capture_mode;
        logic t0;
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'h01);
        apb(1'b1, timer0_pkg::ADDR_FLAGS, 8'h00);
        apb(1'b1, timer0_pkg::ADDR_EDGE, 8'h01);
        apb(1'b1, timer0_pkg::ADDR_DATA, 8'h09);
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'hBE);
        t0 = tog;
        pins.pulse_ext(7);
        pins.pulse_trig;
        apb(1'b0, timer0_pkg::ADDR_DATA, 8'h00);
        chk(rd, 32'h07);
        chk({31'h0, mflag}, 32'h0);
        pins.pulse_ext(3);
        apb(1'b0, timer0_pkg::ADDR_COUNT, 8'h00);
        chk(rd, 32'h00);
        chk({31'h0, mflag}, 32'h1);
        chk({31'h0, tog}, {31'h0, t0});
        chk({31'h0, pwm}, 32'h0);
        apb(1'b1, timer0_pkg::ADDR_CTRL, 8'hAE);
        apb(1'b0, timer0_pkg::ADDR_DATA, 8'h00);
        chk(rd, 32'h07);
        // Falling edge only: the rise of the trigger must not load
        apb(1'b1, timer0_pkg::ADDR_EDGE, 8'h02);
        pins.pulse_ext(2);
        pins.pulse_trig;
        apb(1'b0, timer0_pkg::ADDR_DATA, 8'h00);
        chk(rd, 32'h02);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        rst_b           = 1'b0;
        ce              = 1'b1;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 12'h000;
        pwdata          = 32'h0;
        error_cnt       = 0;
        samples_checked = 0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        reset_values;
        clock_taps;
        sw_clear;
        ext_count;
        pwm_mode;
        capture_mode;
        close_out;
    end
endmodule
`default_nettype wire

// ### tick_source.sv
// Prescaler taps and external count edge for the timer
`timescale 1ns/1ns
`default_nettype none
module tick_source (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [2:0] cksel,
    input  wire logic       ext_pin,
    output logic            tick
);
    timer0_pkg::tick_state_t s;
    timer0_pkg::tick_state_t next_s;

    // Low bits of the divider that must all be ones for each tap
    function automatic logic [timer0_pkg::PRE_W-1:0] tap_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    tap_mask = 11'h001;
            3'h1:    tap_mask = 11'h003;
            3'h2:    tap_mask = 11'h007;
            3'h3:    tap_mask = 11'h01F;
            3'h4:    tap_mask = 11'h07F;
            3'h5:    tap_mask = 11'h1FF;
            default: tap_mask = 11'h7FF;
        endcase
    endfunction

    always_comb begin
        next_s          = s;
        next_s.div      = s.div + 11'h001;
        next_s.ext_prev = ext_pin;
        if (cksel == timer0_pkg::CK_EXT) begin
            tick = run & ext_pin & ~s.ext_prev;
        end else begin
            tick = run & ((s.div & tap_mask(cksel)) == tap_mask(cksel));
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ### timer0_core.sv
// 8-bit timer with compare, PWM and capture modes behind an APB slave
// ==========================================
`timescale 1ns/1ns
`default_nettype none
module timer0_core (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_input,
    input  wire logic        capture_trigger_input,
    output logic             match_toggle_output,
    output logic             pulse_width_output,
    output logic             match_flag,
    output logic             overflow_flag
);
    timer0_pkg::state_t s;
    timer0_pkg::state_t next_s;
    logic tick;
    logic hit;
    logic access;
    logic wr;
    logic clear_req;
    logic is_timer;
    logic is_pwm;
    logic is_cap;
    logic match_set;
    logic ovf_set;
    logic match_clr;
    logic ovf_clr;
    logic [7:0] count_inc;

    // ==========================================
    // Read mux and address check
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == timer0_pkg::ADDR_CTRL) || (a == timer0_pkg::ADDR_COUNT)
              || (a == timer0_pkg::ADDR_DATA) || (a == timer0_pkg::ADDR_FLAGS)
              || (a == timer0_pkg::ADDR_EDGE);
    endfunction

    function automatic logic [7:0] read_byte(input timer0_pkg::state_t st,
                                             input logic [11:0] a);
        read_byte = 8'h00;
        if (a == timer0_pkg::ADDR_CTRL) begin
            // Clear bit always reads back zero
            read_byte = {st.ctrl.en, 1'b0, st.ctrl.mode, st.ctrl.cksel, 1'b0};
        end else if (a == timer0_pkg::ADDR_COUNT) begin
            read_byte = st.count;
        end else if (a == timer0_pkg::ADDR_DATA) begin
            read_byte = st.ctrl.mode[1] ? st.capture : st.compare;
        end else if (a == timer0_pkg::ADDR_FLAGS) begin
            read_byte = {6'h00, st.ovf_flag, st.match_flag};
        end else if (a == timer0_pkg::ADDR_EDGE) begin
            read_byte = {6'h00, st.edge_cfg};
        end
    endfunction

    // ==========================================
    // Clock source and capture edge detector
    tick_source u_tick (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .run      (s.ctrl.en),
        .cksel    (s.ctrl.cksel),
        .ext_pin  (external_count_input),
        .tick     (tick)
    );

    capture_edge u_edge (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .pin      (capture_trigger_input),
        .edge_cfg (s.edge_cfg),
        .hit      (hit)
    );

    // ==========================================
    // Bus decode
    assign access    = psel & penable & s.pready;
    assign wr        = access & pwrite;
    assign clear_req = wr && (paddr == timer0_pkg::ADDR_CTRL)
                       && pwdata[timer0_pkg::CC_BIT];
    assign is_timer  = (s.ctrl.mode == timer0_pkg::MODE_TIMER);
    assign is_pwm    = (s.ctrl.mode == timer0_pkg::MODE_PWM);
    assign is_cap    = s.ctrl.mode[1];
    assign count_inc = s.count + 8'h01;
    // Flag bank clears on a written zero
    assign match_clr = wr && (paddr == timer0_pkg::ADDR_FLAGS)
                       && !pwdata[timer0_pkg::MATCH_BIT];
    assign ovf_clr   = wr && (paddr == timer0_pkg::ADDR_FLAGS)
                       && !pwdata[timer0_pkg::OVF_BIT];

    // ==========================================
    // Next state
    always_comb begin
        next_s         = s;
        match_set      = 1'b0;
        ovf_set        = 1'b0;
        // One wait state: answer registered on the first access cycle
        next_s.pready  = psel & penable & ~s.pready;
        next_s.pslverr = psel & penable & ~s.pready & ~mapped(paddr);
        next_s.prdata  = 32'h0000_0000;
        if (psel && penable && !s.pready) begin
            next_s.prdata = {24'h00_0000, read_byte(s, paddr)};
        end

        if (wr && (paddr == timer0_pkg::ADDR_CTRL)) begin
            next_s.ctrl.en    = pwdata[timer0_pkg::EN_BIT];
            next_s.ctrl.mode  = pwdata[timer0_pkg::MODE_LO +: 2];
            next_s.ctrl.cksel = pwdata[timer0_pkg::CK_LO +: 3];
        end
        if (wr && (paddr == timer0_pkg::ADDR_DATA)) begin
            next_s.compare = pwdata[7:0];
        end
        if (wr && (paddr == timer0_pkg::ADDR_EDGE)) begin
            next_s.edge_cfg = pwdata[1:0];
        end

        if (clear_req) begin
            next_s.count = 8'h00;
        end else if (s.ctrl.en && tick) begin
            if (is_pwm) begin
                next_s.count = count_inc;
                if (s.count == timer0_pkg::COUNT_MAX) begin
                    ovf_set = 1'b1;
                    next_s.pwm_out = 1'b1;
                end
                if (count_inc == s.compare) begin
                    match_set = 1'b1;
                    next_s.pwm_out = 1'b0;
                end
            end else if (s.count == s.compare) begin
                next_s.count = 8'h00;
                match_set = 1'b1;
                if (is_timer) begin
                    next_s.toggle_out = ~s.toggle_out;
                end
            end else begin
                next_s.count = count_inc;
            end
        end
        if (!is_pwm) begin
            next_s.pwm_out = 1'b0;
        end

        if (s.ctrl.en && is_cap && hit) begin
            next_s.capture = s.count;
        end

        // Set wins over a clear in the same cycle
        next_s.match_flag = (s.match_flag & ~match_clr) | match_set;
        next_s.ovf_flag   = (s.ovf_flag & ~ovf_clr) | ovf_set;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s            <= '0;
            s.ctrl.en    <= timer0_pkg::CTRL_RST[timer0_pkg::EN_BIT];
            s.ctrl.mode  <= timer0_pkg::CTRL_RST[timer0_pkg::MODE_LO +: 2];
            s.ctrl.cksel <= timer0_pkg::CTRL_RST[timer0_pkg::CK_LO +: 3];
            s.compare    <= timer0_pkg::COMPARE_RST;
            s.capture    <= timer0_pkg::CAPTURE_RST;
            s.count      <= timer0_pkg::COUNT_RST;
            s.edge_cfg   <= timer0_pkg::EDGE_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ==========================================
    // Outputs
    assign prdata              = s.prdata;
    assign pready              = s.pready;
    assign pslverr             = s.pslverr;
    assign match_toggle_output = s.toggle_out;
    assign pulse_width_output  = s.pwm_out;
    assign match_flag          = s.match_flag;
    assign overflow_flag       = s.ovf_flag;

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sw_clear_a: assert property (
        ce && clear_req |=> s.count == 8'h00)
        else $error("count not zero after software clear");

    match_reset_a: assert property (
        ce && !clear_req && s.ctrl.en && tick && !is_pwm && s.count == s.compare
        |=> s.count == 8'h00 && s.match_flag)
        else $error("match did not clear count or set flag");

    match_toggle_a: assert property (
        ce && !clear_req && s.ctrl.en && tick && is_timer && s.count == s.compare
        |=> s.toggle_out != $past(s.toggle_out))
        else $error("toggle output did not flip on match");

    pwm_wrap_a: assert property (
        ce && !clear_req && s.ctrl.en && tick && is_pwm && s.count == 8'hFF
        |=> s.count == 8'h00 && s.ovf_flag)
        else $error("pwm wrap missed overflow");

    pwm_no_clear_a: assert property (
        ce && !clear_req && s.ctrl.en && tick && is_pwm && s.count == s.compare
        && s.count != 8'hFF |=> s.count == $past(s.count) + 8'h01)
        else $error("pwm match cleared the count");

    pwm_level_a: assert property (
        ce && !clear_req && s.ctrl.en && tick && is_pwm && s.count == 8'hFF
        && s.compare != 8'h00 |=> s.pwm_out)
        else $error("pwm output not high after wrap");

    capture_load_a: assert property (
        ce && s.ctrl.en && is_cap && hit |=> s.capture == $past(s.count))
        else $error("capture did not load count");

    cap_no_toggle_a: assert property (
        ce && is_cap |=> $stable(s.toggle_out))
        else $error("toggle output moved in capture mode");

    disabled_hold_a: assert property (
        ce && !s.ctrl.en && !clear_req |=> s.count == $past(s.count) && !$rose(s.match_flag))
        else $error("disabled timer changed");

    shared_read_a: assert property (
        ce && psel && penable && !s.pready && !pwrite && is_cap
        && paddr == timer0_pkg::ADDR_DATA |=> s.prdata[7:0] == $past(s.capture))
        else $error("shared address did not return capture");
endmodule
`default_nettype wire

// ### timer0_pkg.sv
// Constants, register map and state types of the 8-bit timer
package timer0_pkg;
    // ==========================================
    // Register indices and byte addresses
    localparam logic [7:0]  IDX_CTRL  = 8'hB2;
    localparam logic [7:0]  IDX_COUNT = 8'hB3;
    localparam logic [7:0]  IDX_DATA  = 8'hB4;
    localparam logic [7:0]  IDX_FLAGS = 8'hB5;
    localparam logic [7:0]  IDX_EDGE  = 8'hB6;
    localparam logic [11:0] ADDR_CTRL  = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] ADDR_COUNT = {2'h0, IDX_COUNT, 2'h0};
    localparam logic [11:0] ADDR_DATA  = {2'h0, IDX_DATA, 2'h0};
    localparam logic [11:0] ADDR_FLAGS = {2'h0, IDX_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_EDGE  = {2'h0, IDX_EDGE, 2'h0};
    // ==========================================
    // Field positions
    localparam int EN_BIT    = 7;
    localparam int MODE_LO   = 4;
    localparam int CK_LO     = 1;
    localparam int CC_BIT    = 0;
    localparam int MATCH_BIT = 0;
    localparam int OVF_BIT   = 1;
    localparam int RISE_BIT  = 0;
    localparam int FALL_BIT  = 1;
    // ==========================================
    // Reset values and codes
    localparam logic [7:0] CTRL_RST    = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'hFF;
    localparam logic [7:0] CAPTURE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST   = 8'h00;
    localparam logic [7:0] COUNT_MAX   = 8'hFF;
    localparam logic [1:0] EDGE_RST    = 2'h1;
    localparam logic [1:0] MODE_TIMER  = 2'h0;
    localparam logic [1:0] MODE_PWM    = 2'h1;
    localparam logic [2:0] CK_EXT      = 3'h7;
    localparam int         PRE_W       = 11;

    typedef struct packed {
        logic       en;
        logic [1:0] mode;
        logic [2:0] cksel;
    } ctrl_t;

    typedef struct packed {
        ctrl_t       ctrl;
        logic [7:0]  compare;
        logic [7:0]  capture;
        logic [7:0]  count;
        logic        match_flag;
        logic        ovf_flag;
        logic [1:0]  edge_cfg;
        logic        toggle_out;
        logic        pwm_out;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;

    typedef struct packed {
        logic [PRE_W-1:0] div;
        logic             ext_prev;
    } tick_state_t;
endpackage
